/* File: plr_regs.svh */
`ifndef PLR_REGS_SVH
`define PLR_REGS_SVH

// register byte offsets
`define PLR_PHY_CTRL_OFS 12'h000
`define PLR_DTE_CTRL_OFS 12'h004
`define PLR_GEN_CFG_OFS 12'h008
`define PLR_PHY_CFG_OFS 12'h018
`define PLR_DTE_CFG_OFS 12'h028
`define PLR_STATUS_OFS 12'h038
`define PLR_CFG_STRIDE 12'h004

// field positions
`define PLR_CTRL_LPBK_BIT 14
`define PLR_CFG_LPBK_BIT 3
`define PLR_ST_POR_BIT 0
`define PLR_ST_PD_BIT 1
`define PLR_ST_ENABLE_BIT 2
`define PLR_ST_LPBK_LSB 4

// reset values
`define PLR_CTRL_RST 16'h0000
`define PLR_CFG_RST 16'h0000

// timing
`define PLR_REF_CLK_MHZ 125
`define PLR_POR_LIMIT_NS 1000000
`define PLR_POR_LIMIT_CYC ((`PLR_POR_LIMIT_NS * `PLR_REF_CLK_MHZ) / 1000)

`endif

/* File: plr_pkg.sv */
package plr_pkg;

    typedef enum logic [1:0] {
        PLR_POWER_DOWN,
        PLR_POR_RUN,
        PLR_ACTIVE
    } plr_state_type;

    typedef logic [15:0] plr_reg16_type;

endpackage

/* File: plr_lane_if.sv */
`timescale 1ns/1ns
interface plr_lane_if #(
    parameter int WORD_W = 10
);
    logic power_down;
    logic por_active;
    logic global_lpbk;
    logic cfg_lpbk;
    logic lpbk_pin;
    logic tx_serial;
    logic rx_serial_pin;
    logic [WORD_W-1:0] rx_word;
    logic rx_clk_src;
    logic loopback_en;
    logic tx_serial_out;
    logic tx_serial_oe;
    logic rx_serial_deser;
    logic [WORD_W-1:0] rx_data;
    logic rx_data_oe;
    logic rx_clk_out;

    modport ctrl (
        output power_down, por_active, global_lpbk, cfg_lpbk, lpbk_pin,
        output tx_serial, rx_serial_pin, rx_word, rx_clk_src,
        input loopback_en, tx_serial_out, tx_serial_oe, rx_serial_deser,
        input rx_data, rx_data_oe, rx_clk_out
    );
    modport lane (
        input power_down, por_active, global_lpbk, cfg_lpbk, lpbk_pin,
        input tx_serial, rx_serial_pin, rx_word, rx_clk_src,
        output loopback_en, tx_serial_out, tx_serial_oe, rx_serial_deser,
        output rx_data, rx_data_oe, rx_clk_out
    );
endinterface

/* File: plr_lane.sv */
`timescale 1ns/1ns
module plr_lane #(
    parameter int WORD_W = 10
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // lane signals
    plr_lane_if.lane lane
);

    logic [WORD_W-1:0] rx_data_reg;
    logic quiet;

    assign quiet = lane.power_down | lane.por_active;

    // [R11] or of sources
    assign lane.loopback_en = lane.lpbk_pin | lane.cfg_lpbk | lane.global_lpbk;

    // [R06] serial wrap
    assign lane.rx_serial_deser = lane.loopback_en ? lane.tx_serial : lane.rx_serial_pin;

    assign lane.tx_serial_out = lane.tx_serial;
    // [R02] [R07] driver released
    assign lane.tx_serial_oe = ~(lane.power_down | lane.loopback_en);

    // [R09] clock held low
    assign lane.rx_clk_out = lane.rx_clk_src & ~quiet;

    // [R02] [R09] bus released
    assign lane.rx_data_oe = ~quiet;

    // cleared while quiet so no stale word shows on release
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_data_reg <= '0;
        end else if (quiet) begin
            rx_data_reg <= '0;
        end else begin
            rx_data_reg <= lane.rx_word;
        end
    end

    assign lane.rx_data = rx_data_reg;

endmodule

/* File: plr_ctrl.sv */
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "plr_regs.svh"

// How it works
// [R01] enable pin low puts the whole block into power-down, logic disabled
// [R02] power-down floats serial transmit outputs and receive parallel buses
// [R03] a lane loopback pin high enables internal loopback for that lane
// [R04] bit 14 of either global control register enables loopback everywhere
// [R05] bit 3 of a channel configuration register enables that lane's loopback
// [R06] in loopback, transmit serial data feeds the same lane's receiver
// [R07] in loopback, the lane's serial output driver is released
// [R08] an internal power-on reset runs after power is valid, no pin needed
// [R09] during power-on reset receive buses float and recovered clocks stay low
// [R10] power-on reset lasts a fixed reference clock count, below 1 ms
// [R11] lane loopback is the or of pin, channel bit and global bits
module plr_ctrl #(
    parameter int NUM_LANES = 4,
    parameter int WORD_W = 10,
    parameter int POR_CYCLES = `PLR_POR_LIMIT_CYC - 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,

    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,

    // power pin
    input wire logic enable_pin_i,

    // per-lane pins
    input wire logic [NUM_LANES-1:0] lane_loopback_pin_i,
    output logic [NUM_LANES-1:0] tx_serial_o,
    output logic [NUM_LANES-1:0] tx_serial_oe_o,
    input wire logic [NUM_LANES-1:0] rx_serial_pin_i,
    output logic [NUM_LANES-1:0][WORD_W-1:0] rx_parallel_data_o,
    output logic [NUM_LANES-1:0] rx_parallel_data_oe_o,
    output logic [NUM_LANES-1:0] rx_recovered_clock_o,

    // datapath side
    input wire logic [NUM_LANES-1:0] tx_serial_i,
    output logic [NUM_LANES-1:0] lane_rx_serial_o,
    input wire logic [NUM_LANES-1:0][WORD_W-1:0] rx_word_i,
    input wire logic [NUM_LANES-1:0] rx_clk_src_i,
    output logic [NUM_LANES-1:0] lane_loopback_o,
    output logic core_enable_o,
    output logic core_reset_o
);

    localparam int CNT_W = $clog2(POR_CYCLES + 1);
    // index of a channel within one register set
    localparam int CFG_W = $clog2(NUM_LANES);

    // the map has exactly four channel slots per set
    if (NUM_LANES != 4) begin : g_bad_lanes
        $error("plr_ctrl: NUM_LANES must be 4");
    end
    if (WORD_W < 1) begin : g_bad_word
        $error("plr_ctrl: WORD_W must be at least 1");
    end
    if (POR_CYCLES < 1 || POR_CYCLES >= `PLR_POR_LIMIT_CYC) begin : g_bad_por
        $error("plr_ctrl: POR_CYCLES must be 1 up to below the 1 ms count");
    end

    plr_pkg::plr_state_type state_reg;
    plr_pkg::plr_state_type state_next;
    logic [CNT_W-1:0] por_cnt_reg;
    logic por_done;

    plr_pkg::plr_reg16_type phy_ctrl_reg;
    plr_pkg::plr_reg16_type dte_ctrl_reg;
    plr_pkg::plr_reg16_type gen_cfg_reg [NUM_LANES];
    plr_pkg::plr_reg16_type phy_cfg_reg [NUM_LANES];
    plr_pkg::plr_reg16_type dte_cfg_reg [NUM_LANES];

    logic power_down;
    logic por_active;
    logic global_lpbk;
    logic [NUM_LANES-1:0] lane_lpbk;

    logic access;
    logic access_ok;
    logic wr_en;
    logic addr_hit;
    logic [31:0] rd_data;
    logic [15:0] wr_half;
    logic [15:0] wr_mask;
    logic is_phy_ctrl;
    logic is_dte_ctrl;
    logic is_status;
    logic is_gen;
    logic is_phy_cfg;
    logic is_dte_cfg;
    logic [CFG_W-1:0] cfg_idx;
    logic [11:0] gen_rel;
    logic [11:0] phy_rel;
    logic [11:0] dte_rel;

    // power state machine

    // [R10] reset length counted in ref clocks
    // count stops here; leaving the state clears it for the next run
    assign por_done = (por_cnt_reg == CNT_W'(POR_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            plr_pkg::PLR_POWER_DOWN: begin
                // [R08] reset restarts on power valid
                if (enable_pin_i) begin
                    state_next = plr_pkg::PLR_POR_RUN;
                end
            end
            plr_pkg::PLR_POR_RUN: begin
                // [R01] pin low wins
                if (!enable_pin_i) begin
                    state_next = plr_pkg::PLR_POWER_DOWN;
                end else if (por_done) begin
                    state_next = plr_pkg::PLR_ACTIVE;
                end
            end
            plr_pkg::PLR_ACTIVE: begin
                // [R01] enter power-down
                if (!enable_pin_i) begin
                    state_next = plr_pkg::PLR_POWER_DOWN;
                end
            end
            // unused code: fall back to the quiet state
            default: begin
                state_next = plr_pkg::PLR_POWER_DOWN;
            end
        endcase
    end

    // [R08] reset starts on its own after rst_i
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= plr_pkg::PLR_POR_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // [R10] count periods of reference clock
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_cnt_reg <= '0;
        end else if (state_reg == plr_pkg::PLR_POR_RUN && !por_done) begin
            por_cnt_reg <= por_cnt_reg + CNT_W'(1);
        end else if (state_reg != plr_pkg::PLR_POR_RUN) begin
            por_cnt_reg <= '0;
        end
    end

    assign power_down = (state_reg == plr_pkg::PLR_POWER_DOWN);
    assign por_active = (state_reg == plr_pkg::PLR_POR_RUN);

    // [R01] core logic disabled in power-down
    assign core_enable_o = ~power_down;
    // core also held in reset while powered down, so it always restarts clean
    assign core_reset_o = por_active | power_down;

    // apb slave, zero wait states
    assign access = psel_i & penable_i;
    // management is part of the disabled logic, so no writes and only status reads until active
    assign access_ok = (state_reg == plr_pkg::PLR_ACTIVE);
    assign wr_en = access & pwrite_i & access_ok & addr_hit;
    // storage is plain flip-flops, so no wait state is ever needed
    assign pready_o = 1'b1;
    // status stays readable when not active, but the refusal is still flagged
    assign pslverr_o = access & (~access_ok | ~addr_hit);

    assign gen_rel = paddr_i - `PLR_GEN_CFG_OFS;
    assign phy_rel = paddr_i - `PLR_PHY_CFG_OFS;
    assign dte_rel = paddr_i - `PLR_DTE_CFG_OFS;

    always_comb begin
        is_phy_ctrl = (paddr_i == `PLR_PHY_CTRL_OFS);
        is_dte_ctrl = (paddr_i == `PLR_DTE_CTRL_OFS);
        is_status = (paddr_i == `PLR_STATUS_OFS);
        is_gen = (paddr_i[1:0] == 2'h0) && (paddr_i >= `PLR_GEN_CFG_OFS)
            && (paddr_i < `PLR_PHY_CFG_OFS);
        is_phy_cfg = (paddr_i[1:0] == 2'h0) && (paddr_i >= `PLR_PHY_CFG_OFS)
            && (paddr_i < `PLR_DTE_CFG_OFS);
        is_dte_cfg = (paddr_i[1:0] == 2'h0) && (paddr_i >= `PLR_DTE_CFG_OFS)
            && (paddr_i < `PLR_STATUS_OFS);
        // the three channel sets decode alike; only the base differs
        cfg_idx = '0;
        if (is_gen) begin
            cfg_idx = gen_rel[CFG_W+1:2];
        end else if (is_phy_cfg) begin
            cfg_idx = phy_rel[CFG_W+1:2];
        end else if (is_dte_cfg) begin
            cfg_idx = dte_rel[CFG_W+1:2];
        end
        addr_hit = is_phy_ctrl | is_dte_ctrl | is_status | is_gen | is_phy_cfg | is_dte_cfg;
    end

    // byte lanes 0 and 1 only; upper lanes hit no storage
    assign wr_mask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign wr_half = pwdata_i[15:0];

    // everything returns to defaults while the block is not active
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_ctrl_reg <= `PLR_CTRL_RST;
        end else if (!access_ok) begin
            phy_ctrl_reg <= `PLR_CTRL_RST;
        end else if (wr_en && is_phy_ctrl) begin
            phy_ctrl_reg <= (phy_ctrl_reg & ~wr_mask) | (wr_half & wr_mask);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dte_ctrl_reg <= `PLR_CTRL_RST;
        end else if (!access_ok) begin
            dte_ctrl_reg <= `PLR_CTRL_RST;
        end else if (wr_en && is_dte_ctrl) begin
            dte_ctrl_reg <= (dte_ctrl_reg & ~wr_mask) | (wr_half & wr_mask);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                gen_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (!access_ok) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                gen_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (wr_en && is_gen) begin
            gen_cfg_reg[cfg_idx] <= (gen_cfg_reg[cfg_idx] & ~wr_mask) | (wr_half & wr_mask);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                phy_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (!access_ok) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                phy_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (wr_en && is_phy_cfg) begin
            phy_cfg_reg[cfg_idx] <= (phy_cfg_reg[cfg_idx] & ~wr_mask) | (wr_half & wr_mask);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                dte_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (!access_ok) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                dte_cfg_reg[i] <= `PLR_CFG_RST;
            end
        end else if (wr_en && is_dte_cfg) begin
            dte_cfg_reg[cfg_idx] <= (dte_cfg_reg[cfg_idx] & ~wr_mask) | (wr_half & wr_mask);
        end
    end

    // read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (is_phy_ctrl) begin
            rd_data[15:0] = phy_ctrl_reg;
        end else if (is_dte_ctrl) begin
            rd_data[15:0] = dte_ctrl_reg;
        end else if (is_gen) begin
            rd_data[15:0] = gen_cfg_reg[cfg_idx];
        end else if (is_phy_cfg) begin
            rd_data[15:0] = phy_cfg_reg[cfg_idx];
        end else if (is_dte_cfg) begin
            rd_data[15:0] = dte_cfg_reg[cfg_idx];
        end else if (is_status) begin
            rd_data[`PLR_ST_POR_BIT] = por_active;
            rd_data[`PLR_ST_PD_BIT] = power_down;
            rd_data[`PLR_ST_ENABLE_BIT] = enable_pin_i;
            rd_data[`PLR_ST_LPBK_LSB +: NUM_LANES] = lane_lpbk;
        end
    end

    // captured at setup so the access phase returns a settled word
    // only status is readable outside the active state
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= (access_ok || is_status) ? rd_data : 32'h0000_0000;
        end
    end

    // [R04] either control bit loops all lanes
    assign global_lpbk = phy_ctrl_reg[`PLR_CTRL_LPBK_BIT] | dte_ctrl_reg[`PLR_CTRL_LPBK_BIT];

    // lanes
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        plr_lane_if #(.WORD_W(WORD_W)) lane_bus ();

        assign lane_bus.power_down = power_down;
        assign lane_bus.por_active = por_active;
        assign lane_bus.global_lpbk = global_lpbk;
        // [R05] per-channel bit from any set
        assign lane_bus.cfg_lpbk = gen_cfg_reg[g][`PLR_CFG_LPBK_BIT]
            | phy_cfg_reg[g][`PLR_CFG_LPBK_BIT] | dte_cfg_reg[g][`PLR_CFG_LPBK_BIT];
        // [R03] dedicated lane pin
        assign lane_bus.lpbk_pin = lane_loopback_pin_i[g];
        assign lane_bus.tx_serial = tx_serial_i[g];
        assign lane_bus.rx_serial_pin = rx_serial_pin_i[g];
        assign lane_bus.rx_word = rx_word_i[g];
        assign lane_bus.rx_clk_src = rx_clk_src_i[g];

        plr_lane #(.WORD_W(WORD_W)) u_lane (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .lane(lane_bus.lane)
        );

        // status and datapath see the same effective enable
        assign lane_lpbk[g] = lane_bus.loopback_en;
        assign lane_loopback_o[g] = lane_bus.loopback_en;
        assign tx_serial_o[g] = lane_bus.tx_serial_out;
        assign tx_serial_oe_o[g] = lane_bus.tx_serial_oe;
        assign lane_rx_serial_o[g] = lane_bus.rx_serial_deser;
        assign rx_parallel_data_o[g] = lane_bus.rx_data;
        assign rx_parallel_data_oe_o[g] = lane_bus.rx_data_oe;
        assign rx_recovered_clock_o[g] = lane_bus.rx_clk_out;
    end

endmodule

/* File: plr_far_mdl.sv */
`timescale 1ns/1ns
module plr_far_mdl (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // datapath side
    output logic [3:0] tx_serial_o,
    output logic [3:0] rx_serial_o,
    output logic [3:0][9:0] rx_word_o,
    output logic [3:0] rx_clk_o
);
    logic [9:0] cnt_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // serial lines differ so a wrong route shows
    assign tx_serial_o = cnt_reg[3:0];
    assign rx_serial_o = ~cnt_reg[4:1];
    assign rx_clk_o = {4{cnt_reg[0]}};
    assign rx_word_o = {cnt_reg ^ 10'h3C0, cnt_reg ^ 10'h280, cnt_reg ^ 10'h140, cnt_reg};
endmodule

/* File: plr_ctrl_monitor.sv */
`timescale 1ns/1ns
module plr_ctrl_chk #(
    parameter int NUM_LANES = 4,
    parameter int WORD_W = 10,
    parameter int POR_CYCLES = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    // pins
    input wire logic enable_pin_i,
    input wire logic [NUM_LANES-1:0] lane_loopback_pin_i,
    input wire logic [NUM_LANES-1:0] tx_serial_oe_o,
    input wire logic [NUM_LANES-1:0] rx_serial_pin_i,
    input wire logic [NUM_LANES-1:0] rx_parallel_data_oe_o,
    input wire logic [NUM_LANES-1:0] rx_recovered_clock_o,
    // datapath side
    input wire logic [NUM_LANES-1:0] tx_serial_i,
    input wire logic [NUM_LANES-1:0] lane_rx_serial_o,
    input wire logic [NUM_LANES-1:0] lane_loopback_o,
    input wire logic core_enable_o,
    input wire logic core_reset_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic wr_ok;
    logic [1:0] sel;
    logic [31:0] por_cnt;
    logic [3:0] hit_q;

    assign wr_ok = psel_i && penable_i && pwrite_i && enable_pin_i && core_enable_o
        && !core_reset_o;
    // channel sets repeat every four words from 0x008
    assign sel = paddr_i[3:2] - 2'h2;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_cnt <= 32'h0;
            hit_q <= 4'h0;
        end else begin
            por_cnt <= (core_reset_o && core_enable_o) ? por_cnt + 32'h1 : 32'h0;
            hit_q <= (wr_ok && pwdata_i[3] && pstrb_i[0] && paddr_i >= 12'h008
                && paddr_i <= 12'h034 && paddr_i[1:0] == 2'h0) ? 4'h1 << sel : 4'h0;
        end
    end

    a_pd_core_off: assert property (!enable_pin_i |=> !core_enable_o && core_reset_o)
        else $error("logic active in power-down");
    a_pd_pins_float: assert property (!enable_pin_i |=> ~|tx_serial_oe_o && ~|rx_parallel_data_oe_o)
        else $error("pins driven in power-down");
    a_pin_loop: assert property (core_enable_o |-> ~|(lane_loopback_pin_i & ~lane_loopback_o))
        else $error("loopback pin ignored");
    a_glob_loop: assert property (wr_ok && paddr_i[11:3] == 9'h000 && paddr_i[1:0] == 2'h0
        && pwdata_i[14] && pstrb_i[1] |=> &lane_loopback_o)
        else $error("global loopback bit ignored");
    a_cfg_loop: assert property (hit_q != 4'h0 |-> (lane_loopback_o & hit_q) == hit_q)
        else $error("channel loopback bit ignored");
    a_loop_route: assert property (lane_rx_serial_o == ((lane_loopback_o & tx_serial_i)
        | (~lane_loopback_o & rx_serial_pin_i)))
        else $error("receiver input misrouted");
    a_loop_txoff: assert property (~|(lane_loopback_o & tx_serial_oe_o))
        else $error("serial output driven in loopback");
    a_por_quiet: assert property (core_reset_o |-> ~|rx_parallel_data_oe_o && ~|rx_recovered_clock_o)
        else $error("receive pins active in power-on reset");
    a_por_length: assert property ($fell(core_reset_o) && core_enable_o |-> por_cnt == POR_CYCLES)
        else $error("power-on reset length wrong");
    a_por_bound: assert property (por_cnt <= POR_CYCLES)
        else $error("power-on reset overran");
endmodule

bind plr_ctrl plr_ctrl_chk #(.NUM_LANES(NUM_LANES), .WORD_W(WORD_W), .POR_CYCLES(POR_CYCLES))
    chk_u (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .enable_pin_i, .lane_loopback_pin_i, .tx_serial_oe_o, .rx_serial_pin_i,
    .rx_parallel_data_oe_o, .rx_recovered_clock_o, .tx_serial_i, .lane_rx_serial_o,
    .lane_loopback_o, .core_enable_o, .core_reset_o);

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    localparam int POR = 8;
    logic clk, rst, psel, pen, pwr, pready, pslverr, en_pin, core_en, core_rst, erv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] pstrb, lb_pin, tx_s, tx_out, tx_oe, rx_pin, rx_oe, rx_clk, rx_rc, lane_rx, lane_lb;
    logic [3:0][9:0] rx_w, rx_d, w;
    int mismatches, n_checks, n;

    plr_ctrl #(.POR_CYCLES(POR)) dut_u (
        .ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .enable_pin_i(en_pin),
        .lane_loopback_pin_i(lb_pin), .tx_serial_o(tx_out), .tx_serial_oe_o(tx_oe),
        .rx_serial_pin_i(rx_pin), .rx_parallel_data_o(rx_d), .rx_parallel_data_oe_o(rx_oe),
        .rx_recovered_clock_o(rx_rc), .tx_serial_i(tx_s), .lane_rx_serial_o(lane_rx),
        .rx_word_i(rx_w), .rx_clk_src_i(rx_clk), .lane_loopback_o(lane_lb),
        .core_enable_o(core_en), .core_reset_o(core_rst)
    );
    plr_far_mdl far_u (.ref_clk_i(clk), .rst_i(rst), .tx_serial_o(tx_s), .rx_serial_o(rx_pin),
        .rx_word_o(rx_w), .rx_clk_o(rx_clk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // apb transfer; ends just after the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk({31'h0, erv}, {31'h0, e});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rdv, x);
        chk({31'h0, erv}, {31'h0, e});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // whole sequence needs well under 1000 cycles
    initial begin
        #30000;
        mismatches++;
        $display("[ERR] %0t timeout", $time);
        test_done;
    end

    initial begin
        rst = 1'b1;
        {psel, pen, pwr, paddr, pwdata, lb_pin} = '0;
        pstrb = 4'h3;
        en_pin = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({31'h0, core_rst}, 32'h1);
        chk({28'h0, rx_oe}, 32'h0);
        n = 0;
        while (core_rst === 1'b1) begin
            chk({28'h0, rx_rc}, 32'h0);
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, POR);
        rd(12'h038, 32'h4, 1'b0);
        $display("power-on reset test done");
        for (int i = 0; i < 2; i++) begin
            wr(12'(4 * i), 32'h4000, 1'b0);
            chk({28'h0, lane_lb}, 32'hF);
            chk({28'h0, tx_oe}, 32'h0);
            chk({28'h0, lane_rx}, {28'h0, tx_s});
            rd(12'h038, 32'hF4, 1'b0);
            wr(12'(4 * i), 32'h0, 1'b0);
            chk({28'h0, tx_oe}, 32'hF);
            chk({28'h0, lane_rx}, {28'h0, rx_pin});
            chk({28'h0, tx_out}, {28'h0, tx_s});
        end
        $display("global loopback test done");
        for (int s = 0; s < 3; s++) begin
            for (int l = 0; l < 4; l++) begin
                wr(12'h008 + 12'(16 * s + 4 * l), 32'h8, 1'b0);
                chk({28'h0, lane_lb}, 32'h1 << l);
                rd(12'h008 + 12'(16 * s + 4 * l), 32'h8, 1'b0);
                wr(12'h008 + 12'(16 * s + 4 * l), 32'h0, 1'b0);
            end
        end
        $display("channel loopback test done");
        for (int g = 0; g < 4; g++) begin
            @(posedge clk);
            lb_pin <= 4'h1 << g;
            #1;
            chk({28'h0, lane_lb}, 32'h1 << g);
            chk({28'h0, tx_oe}, ~(32'h1 << g) & 32'hF);
        end
        @(posedge clk);
        lb_pin <= 4'h1;
        wr(12'h014, 32'h8, 1'b0);
        chk({28'h0, lane_lb}, 32'h9);
        wr(12'h014, 32'h0, 1'b0);
        @(posedge clk);
        lb_pin <= 4'h0;
        $display("loopback pin test done");
        #1;
        w = rx_w;
        @(posedge clk);
        #1;
        chk({22'h0, rx_d[2]}, {22'h0, w[2]});
        chk({28'h0, rx_oe}, 32'hF);
        chk({28'h0, rx_rc}, {28'h0, rx_clk});
        rd(12'h03C, 32'h0, 1'b1);
        wr(12'h002, 32'h4000, 1'b1);
        chk({28'h0, lane_lb}, 32'h0);
        $display("data and address test done");
        wr(12'h000, 32'h4000, 1'b0);
        @(posedge clk);
        en_pin <= 1'b0;
        @(posedge clk);
        #1;
        chk({28'h0, tx_oe}, 32'h0);
        chk({28'h0, rx_oe}, 32'h0);
        chk({30'h0, core_en, core_rst}, 32'h1);
        rd(12'h038, 32'h2, 1'b1);
        wr(12'h008, 32'h8, 1'b1);
        @(posedge clk);
        en_pin <= 1'b1;
        #1;
        n = 0;
        while (core_rst === 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, POR + 1);
        rd(12'h038, 32'h4, 1'b0);
        $display("power-down test done");
        test_done;
    end
endmodule
